/* File: logic/jtgsh_pkg.sv */
/*
  Constants and types shared by the scan-port block: pin map, instruction
  codes, register lengths, reset values and the one-hot controller states.
  Assumes a single system clock; nothing here depends on the clock rate.
*/
`default_nettype none

package jtgsh_pkg;

  // ==========================================================================
  // shared pin map, test mode on the left, general purpose on the right
  localparam int PIN_COUNT = 5;
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;
  localparam int PIN_TRST = 4;

  // ==========================================================================
  // register lengths
  localparam int IR_LEN = 4;
  localparam int DR_LEN = 32;
  localparam int BSR_LEN = 8;
  localparam int BYPASS_LEN = 1;

  // ==========================================================================
  // instruction codes (all-ones is bypass; unknown codes also act as bypass)
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_PRELOAD = 4'h2;
  localparam logic [3:0] INS_IDCODE = 4'h3;
  localparam logic [3:0] INS_CLAMP = 4'h4;
  localparam logic [3:0] INS_HIGHZ = 4'h5;
  localparam logic [3:0] INS_BYPASS = 4'hF;

  // ==========================================================================
  // capture and reset values
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = INS_IDCODE;
  // arbitrary identification word; bit 0 must stay one
  localparam logic [31:0] IDCODE_VALUE = 32'h0A5A_5001;
  localparam logic [7:0] BSR_RESET = 8'h00;

  // ==========================================================================
  // controller states
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtgsh_state_t;

endpackage

`default_nettype wire

/* File: logic/jtgsh_tap_if.sv */
/*
  Carrier between the pin-sharing top and the scan controller.
  Assumes both ends run on the same system clock.
*/
`default_nettype none

interface jtgsh_tap_if;
  logic tckRise;
  logic tms;
  logic holdReset;
  jtgsh_pkg::jtgsh_state_t state;

  modport fsm (
    input tckRise,
    input tms,
    input holdReset,
    output state
  );

  modport core (
    output tckRise,
    output tms,
    output holdReset,
    input state
  );
endinterface

`default_nettype wire

/* File: logic/jtgsh_tap_fsm.sv */
/*
  Sixteen-state scan controller, stepped on sampled rising test-clock edges.
  Assumes the top supplies already synchronised test-clock edges and mode pin.
*/
`default_nettype none

module jtgsh_tap_fsm (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  jtgsh_tap_if.fsm tap
);

  // ==========================================================================
  // next-state decode
  function automatic jtgsh_pkg::jtgsh_state_t stepState(
    input jtgsh_pkg::jtgsh_state_t cur,
    input logic tmsBit
  );
    case (cur)
      jtgsh_pkg::ST_RESET: stepState = tmsBit ? jtgsh_pkg::ST_RESET : jtgsh_pkg::ST_IDLE;
      jtgsh_pkg::ST_IDLE: stepState = tmsBit ? jtgsh_pkg::ST_SEL_DR : jtgsh_pkg::ST_IDLE;
      jtgsh_pkg::ST_SEL_DR: stepState = tmsBit ? jtgsh_pkg::ST_SEL_IR : jtgsh_pkg::ST_CAP_DR;
      jtgsh_pkg::ST_CAP_DR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT1_DR : jtgsh_pkg::ST_SHIFT_DR;
      jtgsh_pkg::ST_SHIFT_DR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT1_DR : jtgsh_pkg::ST_SHIFT_DR;
      jtgsh_pkg::ST_EXIT1_DR: stepState = tmsBit ? jtgsh_pkg::ST_UPD_DR : jtgsh_pkg::ST_PAUSE_DR;
      jtgsh_pkg::ST_PAUSE_DR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT2_DR : jtgsh_pkg::ST_PAUSE_DR;
      jtgsh_pkg::ST_EXIT2_DR: stepState = tmsBit ? jtgsh_pkg::ST_UPD_DR : jtgsh_pkg::ST_SHIFT_DR;
      jtgsh_pkg::ST_UPD_DR: stepState = tmsBit ? jtgsh_pkg::ST_SEL_DR : jtgsh_pkg::ST_IDLE;
      jtgsh_pkg::ST_SEL_IR: stepState = tmsBit ? jtgsh_pkg::ST_RESET : jtgsh_pkg::ST_CAP_IR;
      jtgsh_pkg::ST_CAP_IR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT1_IR : jtgsh_pkg::ST_SHIFT_IR;
      jtgsh_pkg::ST_SHIFT_IR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT1_IR : jtgsh_pkg::ST_SHIFT_IR;
      jtgsh_pkg::ST_EXIT1_IR: stepState = tmsBit ? jtgsh_pkg::ST_UPD_IR : jtgsh_pkg::ST_PAUSE_IR;
      jtgsh_pkg::ST_PAUSE_IR: stepState = tmsBit ? jtgsh_pkg::ST_EXIT2_IR : jtgsh_pkg::ST_PAUSE_IR;
      jtgsh_pkg::ST_EXIT2_IR: stepState = tmsBit ? jtgsh_pkg::ST_UPD_IR : jtgsh_pkg::ST_SHIFT_IR;
      jtgsh_pkg::ST_UPD_IR: stepState = tmsBit ? jtgsh_pkg::ST_SEL_DR : jtgsh_pkg::ST_IDLE;
      default: stepState = jtgsh_pkg::ST_RESET;
    endcase
  endfunction

  jtgsh_pkg::jtgsh_state_t next_state;

  assign next_state = tap.holdReset ? jtgsh_pkg::ST_RESET :                  // [RQ7]
                      tap.tckRise ? stepState(tap.state, tap.tms) : tap.state; // [RQ2]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tap.state <= jtgsh_pkg::ST_RESET;
    end else if (clkEnable) begin
      tap.state <= next_state;
    end
  end

endmodule

`default_nettype wire

/* File: logic/jtgsh_top.sv */
/*
  Scan test port sharing five general-purpose pins, with instruction and
  data registers and a small boundary register for the core's pins.
  Assumes pins arrive asynchronously and that the test clock runs well below
  a quarter of the system clock, since its edges are found by oversampling.
*/
// Notes on behaviour
// RQ1: scan port live only while test select low
// RQ2: standard controller, instruction and data registers
// RQ3: decode IDCODE BYPASS EXTEST SAMPLE PRELOAD HIGHZ CLAMP
// RQ4: pins 0-4 become TCK TMS TDI TDO TRSTn
// RQ5: test select low forces non-operational mode
// RQ6: controller pulses master reset after leaving test (not done here: the top has no reset output, reset comes from outside)
// RQ7: controller held reset while test select high
`default_nettype none

module jtgsh_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic testModeSelectN,
  input wire logic [4:0] gpioPinIn,
  output logic [4:0] gpioPinOut,
  output logic [4:0] gpioPinOe,
  input wire logic [4:0] gpioCoreOut,
  input wire logic [4:0] gpioCoreOe,
  output logic [4:0] gpioCoreIn,
  output logic nonOperational,
  input wire logic [7:0] bsrSysIn,
  output logic [7:0] bsrDrive,
  output logic bsrTakeover,
  output logic bsrHighZ
);

  // ==========================================================================
  // pin synchronisers
  logic testSelMeta;
  logic testSelSync;
  logic [4:0] pinMeta;
  logic [4:0] pinSync;
  logic tckPrev;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      testSelMeta <= 1'b1;
      testSelSync <= 1'b1;
      pinMeta <= 5'h00;
      pinSync <= 5'h00;
      tckPrev <= 1'b0;
    end else if (clkEnable) begin
      testSelMeta <= testModeSelectN;
      testSelSync <= testSelMeta;
      pinMeta <= gpioPinIn;
      pinSync <= pinMeta;
      tckPrev <= pinSync[jtgsh_pkg::PIN_TCK];
    end
  end

  // ==========================================================================
  // pin roles
  wire testActive = ~testSelSync; // [RQ1]
  wire tckNow = pinSync[jtgsh_pkg::PIN_TCK];
  wire tckRise = testActive & tckNow & ~tckPrev;
  wire tckFall = testActive & ~tckNow & tckPrev;
  wire tdiBit = pinSync[jtgsh_pkg::PIN_TDI];
  // gpio activity is ignored outside test mode
  wire holdReset = ~testActive | ~pinSync[jtgsh_pkg::PIN_TRST]; // [RQ7]

  jtgsh_tap_if tap ();

  assign tap.tckRise = tckRise;
  assign tap.tms = pinSync[jtgsh_pkg::PIN_TMS];
  assign tap.holdReset = holdReset;

  jtgsh_tap_fsm jtgsh_tap_fsm_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEnable(clkEnable),
    .tap(tap)
  );

  wire inReset = (tap.state == jtgsh_pkg::ST_RESET);
  wire capIr = (tap.state == jtgsh_pkg::ST_CAP_IR);
  wire shiftIr = (tap.state == jtgsh_pkg::ST_SHIFT_IR);
  wire updIr = (tap.state == jtgsh_pkg::ST_UPD_IR);
  wire capDr = (tap.state == jtgsh_pkg::ST_CAP_DR);
  wire shiftDr = (tap.state == jtgsh_pkg::ST_SHIFT_DR);
  wire updDr = (tap.state == jtgsh_pkg::ST_UPD_DR);

  // ==========================================================================
  // instruction register
  logic [3:0] irShift;
  logic [3:0] irActive;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irShift <= jtgsh_pkg::IR_CAPTURE;
      irActive <= jtgsh_pkg::IR_RESET;
    end else if (clkEnable) begin
      if (inReset) begin
        irActive <= jtgsh_pkg::IR_RESET; // [RQ2]
      end else if (tckFall && updIr) begin
        irActive <= irShift;
      end
      if (tckRise && capIr) begin
        irShift <= jtgsh_pkg::IR_CAPTURE;
      end else if (tckRise && shiftIr) begin
        irShift <= {tdiBit, irShift[3:1]};
      end
    end
  end

  // ==========================================================================
  // instruction decode
  wire insExtest = (irActive == jtgsh_pkg::INS_EXTEST); // [RQ3]
  wire insSample = (irActive == jtgsh_pkg::INS_SAMPLE);
  wire insPreload = (irActive == jtgsh_pkg::INS_PRELOAD);
  wire insIdcode = (irActive == jtgsh_pkg::INS_IDCODE);
  wire insClamp = (irActive == jtgsh_pkg::INS_CLAMP);
  wire insHighz = (irActive == jtgsh_pkg::INS_HIGHZ);
  wire selBsr = insExtest | insSample | insPreload;
  // clamp and highz select bypass while the pins are held, as usual
  wire selBypass = ~selBsr & ~insIdcode;

  function automatic logic [31:0] shiftInAt(
    input logic [31:0] cur,
    input logic bitIn,
    input int len
  );
    logic [31:0] res;
    res = cur >> 1;
    res[len - 1] = bitIn;
    shiftInAt = res;
  endfunction

  // ==========================================================================
  // data register path (idcode, bypass and boundary share one shifter)
  logic [31:0] drShift;
  logic [31:0] drCapture;
  logic [31:0] drShifted;

  assign drCapture = insIdcode ? jtgsh_pkg::IDCODE_VALUE :
                     selBsr ? {24'h000000, bsrSysIn} : 32'h0000_0000;
  assign drShifted = insIdcode ? shiftInAt(drShift, tdiBit, jtgsh_pkg::DR_LEN) :
                     selBsr ? shiftInAt(drShift, tdiBit, jtgsh_pkg::BSR_LEN) :
                     shiftInAt(drShift, tdiBit, jtgsh_pkg::BYPASS_LEN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drShift <= 32'h0000_0000;
    end else if (clkEnable) begin
      if (tckRise && capDr) begin
        drShift <= drCapture; // [RQ3]
      end else if (tckRise && shiftDr) begin
        drShift <= drShifted;
      end
    end
  end

  // ==========================================================================
  // boundary update stage and pin takeover
  logic [7:0] bsrUpdate;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bsrUpdate <= jtgsh_pkg::BSR_RESET;
    end else if (clkEnable) begin
      if (inReset) begin
        bsrUpdate <= jtgsh_pkg::BSR_RESET;
      end else if (tckFall && updDr && selBsr) begin
        bsrUpdate <= drShift[7:0]; // [RQ3]
      end
    end
  end

  // ==========================================================================
  // test data out changes on the falling test clock edge
  logic tdoBit;
  logic tdoEn;

  wire tdoSrc = shiftIr ? irShift[0] : drShift[0];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tdoBit <= 1'b0;
      tdoEn <= 1'b0;
    end else if (clkEnable) begin
      if (holdReset) begin
        tdoBit <= 1'b0;
        tdoEn <= 1'b0;
      end else if (tckFall) begin
        tdoBit <= tdoSrc; // [RQ2]
        tdoEn <= shiftIr | shiftDr;
      end
    end
  end

  // ==========================================================================
  // pin muxing and registered outputs
  wire [4:0] next_gpioPinOut = testActive ? {1'b0, tdoBit, 3'b000} : gpioCoreOut; // [RQ4]
  wire [4:0] next_gpioPinOe = testActive ? {1'b0, tdoEn, 3'b000} : gpioCoreOe;    // [RQ4]
  wire [4:0] next_gpioCoreIn = testActive ? 5'h00 : pinSync;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gpioPinOut <= 5'h00;
      gpioPinOe <= 5'h00;
      gpioCoreIn <= 5'h00;
      nonOperational <= 1'b0;
      bsrDrive <= jtgsh_pkg::BSR_RESET;
      bsrTakeover <= 1'b0;
      bsrHighZ <= 1'b0;
    end else if (clkEnable) begin
      gpioPinOut <= next_gpioPinOut;
      gpioPinOe <= next_gpioPinOe;
      gpioCoreIn <= next_gpioCoreIn;
      // two sync stages and this output register are the only delay; the core must stop at once
      nonOperational <= testActive; // [RQ5]
      bsrDrive <= bsrUpdate;
      bsrTakeover <= testActive & ~inReset & (insExtest | insClamp | insHighz); // [RQ3]
      bsrHighZ <= testActive & ~inReset & insHighz;
    end
  end

endmodule

`default_nettype wire

/* File: sim/jtgsh_monitor.sv */
/*
  Port checker for the scan-port top: pin sharing, mode switching and the
  boundary outputs. Assumes the single system clock and active-high reset.
*/
`default_nettype none

module jtgsh_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic testModeSelectN,
  input wire logic [4:0] gpioPinIn,
  input wire logic [4:0] gpioPinOut,
  input wire logic [4:0] gpioPinOe,
  input wire logic [4:0] gpioCoreOut,
  input wire logic [4:0] gpioCoreOe,
  input wire logic [4:0] gpioCoreIn,
  input wire logic nonOperational,
  input wire logic [7:0] bsrDrive,
  input wire logic bsrTakeover,
  input wire logic bsrHighZ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ==========================================================================
  // assertions (eight settled cycles cover the pin synchronisers)
  a_gpio_out_pass: assert property (testModeSelectN [*8] |->
    gpioPinOut == $past(gpioCoreOut) && gpioPinOe == $past(gpioCoreOe))
    else $error("core drive not passed to pins");
  a_core_in_pass: assert property (testModeSelectN [*8] |->
    gpioCoreIn == $past(gpioPinIn, 3)) else $error("pin level not passed to core");
  a_nonop_rise: assert property ($fell(testModeSelectN) |-> ##[1:4] nonOperational)
    else $error("test select did not stop operation");
  a_nonop_clear: assert property (testModeSelectN [*8] |-> !nonOperational)
    else $error("non-operational outside test mode");
  a_test_pins_quiet: assert property (!testModeSelectN [*8] |->
    nonOperational && gpioCoreIn == 5'h00 && (gpioPinOe & 5'h17) == 5'h00)
    else $error("pins not handed to scan port");
  a_tdo_only: assert property (!testModeSelectN [*8] |-> (gpioPinOut & 5'h17) == 5'h00)
    else $error("scan port drives a pin other than the data output");
  a_gpio_tap_idle: assert property (testModeSelectN [*8] |-> !bsrTakeover && !bsrHighZ)
    else $error("boundary takeover outside test mode");
  a_highz_takeover: assert property (bsrHighZ |-> bsrTakeover)
    else $error("high impedance without takeover");
  a_bsr_frozen: assert property (testModeSelectN [*8] |=> $stable(bsrDrive))
    else $error("boundary update register moved outside test mode");

  // ==========================================================================
  // covers
  c_enter: cover property ($fell(testModeSelectN) ##[1:4] nonOperational);
  c_highz: cover property ($rose(bsrHighZ));
  c_takeover: cover property ($rose(bsrTakeover) && !bsrHighZ);
  c_update: cover property (!testModeSelectN && $changed(bsrDrive));
endmodule

bind jtgsh_top jtgsh_monitor jtgsh_monitor_inst (.clk_sys, .reset, .testModeSelectN,
  .gpioPinIn, .gpioPinOut, .gpioPinOe, .gpioCoreOut, .gpioCoreOe, .gpioCoreIn,
  .nonOperational, .bsrDrive, .bsrTakeover, .bsrHighZ);

`default_nettype wire

/* File: sim/jtgsh_tester.sv */
/*
  Behavioural boundary-scan controller on the five shared pins.
  Assumes the bench resolves pin levels from the device's enables.
*/
`default_nettype none

module jtgsh_tester (
  input wire logic clk_sys,
  input wire logic tdoPin,
  output logic [4:0] pinDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] gp = 5'h00;
  logic jtagOn = 1'b0;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  logic trstN = 1'b1;
  logic lastTdo = 1'b0;

  // ==========================================================================
  // pins: a released data output shows a moving pattern, not a held value
  always @(posedge clk_sys) lastTdo <= tdoPin;
  assign pinDrive = jtagOn ? {trstN, ~lastTdo, tdi, tms, tck} : gp;

  // ==========================================================================
  // one test-clock period, low for five system clocks, then high for six or more
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk_sys);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk_sys);
    q = tdoPin;
    tck <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  // from reset or idle through capture, n shifts, update, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  task automatic pulseTrst;
    @(posedge clk_sys);
    trstN <= 1'b0;
    repeat (6) @(posedge clk_sys);
    trstN <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

/* File: sim/test_jtag_test_port_gpio_share.sv */
/*
  Self-checking bench for the scan-port top with a controller model on pins.
  Assumes the design package and interface are compiled first.
*/
`default_nettype none
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module test_jtag_test_port_gpio_share;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic testModeSelectN = 1'b1;
  logic [4:0] gpioCoreOut = 5'h00;
  logic [4:0] gpioCoreOe = 5'h00;
  logic [7:0] bsrSysIn = 8'h00;
  logic [31:0] d;
  logic [7:0] lastDrive;
  int mismatches = 0;
  int cmpCount = 0;
  int cycles = 0;
  wire logic [4:0] gpioPinIn, gpioPinOut, gpioPinOe, gpioCoreIn, drive;
  wire logic [7:0] bsrDrive;
  wire logic nonOperational, bsrTakeover, bsrHighZ;
  localparam logic [3:0] INS [5] = '{jtgsh_pkg::INS_EXTEST, jtgsh_pkg::INS_SAMPLE,
    jtgsh_pkg::INS_PRELOAD, jtgsh_pkg::INS_CLAMP, jtgsh_pkg::INS_HIGHZ};
  localparam logic [4:0] TAKE = 5'b11001;
  localparam logic [4:0] HIZ = 5'b10000;

  assign gpioPinIn = (gpioPinOe & gpioPinOut) | (~gpioPinOe & drive);
  jtgsh_tester jtgsh_tester_inst (.clk_sys, .tdoPin(gpioPinIn[3]), .pinDrive(drive));
  jtgsh_top jtgsh_top_inst (.clk_sys, .reset, .clkEnable(1'b1), .testModeSelectN,
    .gpioPinIn, .gpioPinOut, .gpioPinOe, .gpioCoreOut, .gpioCoreOe, .gpioCoreIn,
    .nonOperational, .bsrSysIn, .bsrDrive, .bsrTakeover, .bsrHighZ);

  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      endOfTest();
    end
  end

  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic testGpio;
    gpioCoreOut <= 5'h0A;
    gpioCoreOe <= 5'h0E;
    jtgsh_tester_inst.gp <= 5'h15;
    repeat (8) @(posedge clk_sys);
    `CHK("pinOut", 5'h0A, gpioPinOut)
    `CHK("pinOe", 5'h0E, gpioPinOe)
    `CHK("coreIn", 5'h1B, gpioCoreIn)
    `CHK("nonOp", 1'b0, nonOperational)
    // scan traffic while deselected must not reach the controller
    gpioCoreOe <= 5'h00;
    jtgsh_tester_inst.jtagOn <= 1'b1;
    jtgsh_tester_inst.scan(1'b1, {28'h0, jtgsh_pkg::INS_HIGHZ}, 4, d);
    `CHK("hizIdle", 1'b0, bsrHighZ)
  endtask

  task automatic testEnter;
    testModeSelectN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("nonOpOn", 1'b1, nonOperational)
    `CHK("coreInTest", 5'h00, gpioCoreIn)
    `CHK("oeIdle", 5'h00, gpioPinOe)
    jtgsh_tester_inst.scan(1'b0, 32'h0, 32, d);
    `CHK("idcode", jtgsh_pkg::IDCODE_VALUE, d)
    jtgsh_tester_inst.scan(1'b1, {28'h0, jtgsh_pkg::INS_BYPASS}, 4, d);
    `CHK("irCapture", jtgsh_pkg::IR_CAPTURE, d[3:0])
    jtgsh_tester_inst.scan(1'b0, 32'hB6, 9, d);
    `CHK("bypass", 9'h16C, d[8:0])
  endtask

  task automatic testBoundary;
    logic [31:0] din;
    lastDrive = bsrDrive;
    for (int i = 0; i < 5; i++) begin
      bsrSysIn <= 8'h5A ^ 8'(i * 17);
      jtgsh_tester_inst.scan(1'b1, {28'h0, INS[i]}, 4, d);
      din = 32'hC3 + 32'(i);
      jtgsh_tester_inst.scan(1'b0, din, TAKE[i] && !HIZ[i] && i == 3 ? 2 : 8, d);
      if (i < 3) begin
        `CHK("bsrCapture", 8'h5A ^ 8'(i * 17), d[7:0])
        lastDrive = 8'hC3 + 8'(i);
      end else begin
        `CHK("clampBypass", {7'h00, din[0], 1'b0}, d[8:0] & 9'h003)
      end
      repeat (6) @(posedge clk_sys);
      `CHK("bsrDrive", lastDrive, bsrDrive)
      `CHK("takeover", TAKE[i], bsrTakeover)
      `CHK("highZ", HIZ[i], bsrHighZ)
    end
    jtgsh_tester_inst.pulseTrst();
    `CHK("trstTake", 1'b0, bsrTakeover)
    jtgsh_tester_inst.scan(1'b0, 32'h0, 32, d);
    `CHK("trstId", jtgsh_pkg::IDCODE_VALUE, d)
  endtask

  task automatic testExit;
    testModeSelectN <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK("nonOpOff", 1'b0, nonOperational)
    `CHK("takeOff", 1'b0, bsrTakeover)
    // clean restart after leaving test mode
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("pinOutRst", 5'h0A, gpioPinOut)
    `CHK("nonOpRst", 1'b0, nonOperational)
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    testGpio();
    testEnter();
    testBoundary();
    testExit();
    repeat (4) @(posedge clk_sys);
    endOfTest();
  end
endmodule

`undef CHK
`default_nettype wire
